// *** rtl/nand_host_pkg.sv ***
// Constants and carrier types for the NAND flash host controller.
// Assumes a 100 MHz ref_clk; all timing counts are in ref_clk cycles.
`default_nettype none

package nand_host_pkg;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int unsigned PAGE_DATA_BYTES  = 2048;
  localparam int unsigned PAGE_SPARE_BYTES = 128;
  localparam int unsigned PAGE_BYTES       = PAGE_DATA_BYTES + PAGE_SPARE_BYTES;
  localparam int unsigned PAGES_PER_BLOCK  = 64;
  localparam int unsigned BLOCKS           = 2048;
  localparam int unsigned MIN_VALID_BLOCKS = 2008;
  localparam int unsigned MAX_PARTIAL_PROG = 4;
  localparam logic [11:0] COL_LAST         = 12'h87f;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ1      = 8'h00;
  localparam logic [7:0] CMD_READ2      = 8'h30;
  localparam logic [7:0] CMD_READ_CACHE = 8'h31;
  localparam logic [7:0] CMD_READ_LAST  = 8'h3f;
  localparam logic [7:0] CMD_COPY_CACHE = 8'h3a;
  localparam logic [7:0] CMD_PROG1      = 8'h80;
  localparam logic [7:0] CMD_PROG_MP    = 8'h81;
  localparam logic [7:0] CMD_PROG2      = 8'h10;
  localparam logic [7:0] CMD_QUEUE      = 8'h11;
  localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
  localparam logic [7:0] CMD_ERASE1     = 8'h60;
  localparam logic [7:0] CMD_ERASE2     = 8'hd0;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_RESET      = 8'hff;
  localparam int unsigned STATUS_RDY_BIT = 6;

  // ---------------------------------------------------------------
  // Timing: printed figures and derived cycle counts
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_STROBE_NS   = 30;
  localparam int unsigned T_WB_NS       = 100;
  localparam int unsigned T_WHR_NS      = 60;
  localparam int unsigned T_R_US        = 25;
  localparam int unsigned T_DCBSYR2_US  = 30;
  localparam int unsigned T_PROG_US     = 700;
  localparam int unsigned T_BERASE_MS   = 5;
  localparam int unsigned T_RST_US      = 500;
  localparam int unsigned STROBE_CYC =
    (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WB_CYC =
    (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WHR_CYC =
    (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest documented busy, used as a watchdog
  localparam int unsigned BUSY_MAX_CYC =
    T_BERASE_MS * 1000000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_CMD,
    PH_ADDR,
    PH_WDATA,
    PH_RDATA
  } phase_e;

  typedef struct packed {
    phase_e     phase;
    logic [7:0] data;
    logic       wait_ready;
    logic       release_ce;
  } req_s;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic [7:0] io_out;
    logic       io_oe;
  } pins_s;

endpackage : nand_host_pkg

`default_nettype wire

// *** rtl/nand_host_ctrl.sv ***
// Host-side NAND flash byte-bus controller: one request per byte phase.
// Assumes a request source on ref_clk and the device's pins asynchronous.
`default_nettype none

// Notes on behaviour
// - Commands, addresses and data share one eight-bit two-way bus.
// - Host flags a fifth back-to-back partial program of one page between erases as prog_seq_error.
// - Status read reports ready on data bit six.
// - Cache program series ends with normal confirm, else poll and reset.
// - Multi-plane cache series ends with 81h then normal confirm.
// - Host never drives the bus while the device drives it.
// - Data-load column address runs from 0 to 2175.
// - Host adds no ECC; data bytes pass to the bus as the request source sends them.
module nand_host_ctrl #(
  parameter int unsigned BUSY_TIMEOUT = nand_host_pkg::BUSY_MAX_CYC
) (
  input  wire  logic                 ref_clk,
  input  wire  logic                 srst,
  // Request side
  input  wire  logic                 req_valid,
  input  wire  nand_host_pkg::req_s  req,
  output var   logic                 req_ready,
  output var   logic                 rsp_valid,
  output var   logic [7:0]           rsp_data,
  output var   logic                 busy_timeout,
  output var   logic                 prog_seq_error,
  // Device pins
  output var   nand_host_pkg::pins_s pins,
  input  wire  logic [7:0]           io_in,
  input  wire  logic                 ready_busy_n
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] io_s1_q;
  logic [7:0] io_s2_q;
  logic       rb_s1_q;
  logic       rb_s2_q;

  always_ff @(posedge ref_clk) begin
    io_s1_q <= io_in;
    io_s2_q <= io_s1_q;
    rb_s1_q <= ready_busy_n;
    rb_s2_q <= rb_s1_q;
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_WAIT_BUSY,
    ST_WAIT_READY,
    ST_SAMPLE
  } state_e;

  localparam int unsigned CNT_W = $clog2(BUSY_TIMEOUT + 1);

  state_e                    state_q;
  nand_host_pkg::req_s       cur_q;
  logic [CNT_W-1:0]          cnt_q;

  wire logic cnt_zero = (cnt_q == '0);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cur_q   <= '0;
      cnt_q   <= '0;
    end else begin
      if (!cnt_zero) begin
        cnt_q <= cnt_q - 1'b1;
      end
      unique case (state_q)
        ST_IDLE: begin
          if (req_valid) begin
            cur_q   <= req;
            state_q <= ST_SETUP;
            cnt_q   <= CNT_W'(nand_host_pkg::STROBE_CYC);
          end
        end
        ST_SETUP: begin
          if (cnt_zero) begin
            state_q <= ST_STROBE;
            cnt_q   <= CNT_W'(nand_host_pkg::STROBE_CYC);
          end
        end
        ST_STROBE: begin
          if (cnt_zero) begin
            state_q <= (cur_q.phase == nand_host_pkg::PH_RDATA)
                       ? ST_SAMPLE : ST_HOLD;
            cnt_q   <= CNT_W'(nand_host_pkg::WB_CYC);
          end
        end
        ST_SAMPLE: begin
          state_q <= ST_HOLD;
          cnt_q   <= CNT_W'(nand_host_pkg::WHR_CYC);
        end
        ST_HOLD: begin
          if (cnt_zero) begin
            if (cur_q.wait_ready) begin
              state_q <= ST_WAIT_BUSY;
              cnt_q   <= CNT_W'(nand_host_pkg::WB_CYC);
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_WAIT_BUSY: begin
          // Busy may be short; fall through to ready wait after tWB
          if (!rb_s2_q || cnt_zero) begin
            state_q <= ST_WAIT_READY;
            cnt_q   <= CNT_W'(BUSY_TIMEOUT);
          end
        end
        ST_WAIT_READY: begin
          if (rb_s2_q || cnt_zero) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  wire logic is_out = (cur_q.phase != nand_host_pkg::PH_RDATA);
  wire logic active = (state_q == ST_SETUP) || (state_q == ST_STROBE) ||
                      (state_q == ST_SAMPLE) || (state_q == ST_HOLD);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                re_n: 1'b1, io_out: 8'h00, io_oe: 1'b0};
    end else begin
      pins.ce_n <= !(active || state_q == ST_WAIT_BUSY ||
                     state_q == ST_WAIT_READY) && cur_q.release_ce;
      pins.cle  <= active && cur_q.phase == nand_host_pkg::PH_CMD;
      pins.ale  <= active && cur_q.phase == nand_host_pkg::PH_ADDR;
      // Write strobe rises leaving ST_STROBE, latching the byte
      pins.we_n <= !(state_q == ST_STROBE && is_out);
      pins.re_n <= !(state_q == ST_STROBE && !is_out);
      // Bytes arrive already ECC-coded from the request source
      pins.io_out <= cur_q.data;
      // Drive only for outgoing phases, never while device reads out
      pins.io_oe  <= active && is_out;
    end
  end

  // ---------------------------------------------------------------
  // Handshake and results
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
    end else begin
      req_ready <= (state_q == ST_IDLE) && !req_valid;
      rsp_valid <= (state_q == ST_SAMPLE) ||
                   (state_q == ST_WAIT_READY && rb_s2_q);
      if (state_q == ST_SAMPLE) begin
        // Sampled after strobe low time; status bit six is ready
        rsp_data <= io_s2_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Partial program count per page
  // ---------------------------------------------------------------
  // Two column bytes come first, then row bytes; erase clears counts
  localparam logic [2:0] PP_MAX = 3'(nand_host_pkg::MAX_PARTIAL_PROG);

  wire logic   take = (state_q == ST_IDLE) && req_valid;
  logic [2:0]  addr_idx_q;
  logic [23:0] row_q;
  logic [23:0] last_row_q;
  logic [2:0]  pp_cnt_q;
  logic        pp_over_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addr_idx_q <= '0;
      row_q      <= '0;
      last_row_q <= '0;
      pp_cnt_q   <= '0;
      pp_over_q  <= 1'b0;
    end else if (take && req.phase == nand_host_pkg::PH_ADDR) begin
      if (addr_idx_q != 3'd7) begin
        addr_idx_q <= addr_idx_q + 3'd1;
      end
      if (addr_idx_q >= 3'd2) begin
        row_q <= {row_q[15:0], req.data};
      end
    end else if (take && req.phase == nand_host_pkg::PH_CMD) begin
      addr_idx_q <= '0;
      if (req.data == nand_host_pkg::CMD_PROG2 ||
          req.data == nand_host_pkg::CMD_CACHE_PROG) begin
        last_row_q <= row_q;
        if (row_q != last_row_q || pp_cnt_q == '0) begin
          pp_cnt_q <= 3'd1;
        end else if (pp_cnt_q == PP_MAX) begin
          pp_over_q <= 1'b1;
        end else begin
          pp_cnt_q <= pp_cnt_q + 3'd1;
        end
      end else if (req.data == nand_host_pkg::CMD_ERASE2) begin
        pp_cnt_q  <= '0;
        pp_over_q <= 1'b0;
      end else if (req.data == nand_host_pkg::CMD_RESET) begin
        pp_over_q <= 1'b0;
      end
    end
  end

  // Watchdog and cache-program termination tracking
  logic cache_open_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_timeout   <= 1'b0;
      prog_seq_error <= 1'b0;
      cache_open_q   <= 1'b0;
    end else begin
      if (state_q == ST_WAIT_READY && !rb_s2_q && cnt_zero) begin
        busy_timeout <= 1'b1;
      end else if (req_valid && state_q == ST_IDLE) begin
        busy_timeout <= 1'b0;
      end
      if (state_q == ST_SETUP && cur_q.phase == nand_host_pkg::PH_CMD) begin
        if (cur_q.data == nand_host_pkg::CMD_CACHE_PROG) begin
          cache_open_q <= 1'b1;
        end else if (cur_q.data == nand_host_pkg::CMD_PROG2 ||
                     cur_q.data == nand_host_pkg::CMD_RESET) begin
          cache_open_q   <= 1'b0;
          prog_seq_error <= 1'b0;
        end else if (cache_open_q &&
                     cur_q.data != nand_host_pkg::CMD_PROG1 &&
                     cur_q.data != nand_host_pkg::CMD_PROG_MP &&
                     cur_q.data != nand_host_pkg::CMD_STATUS) begin
          prog_seq_error <= 1'b1;
        end
      end
      // Too many programs of one page wins over any clear
      if (pp_over_q) begin
        prog_seq_error <= 1'b1;
      end
    end
  end

endmodule : nand_host_ctrl

`default_nettype wire

// *** dv/nand_host_sva.sv ***
// Pin sequencing checks for the NAND host controller.
// Assumes it is bound to nand_host_ctrl and sees only its ports.
`default_nettype none
module nand_host_sva (
  input wire logic                 ref_clk,
  input wire logic                 srst,
  input wire logic                 rsp_valid,
  input wire nand_host_pkg::pins_s pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  strobe_ce_a: assert property (
    !pins.we_n || !pins.re_n |-> !pins.ce_n)
    else $error("strobe low without chip select");
  latch_excl_a: assert property (!(pins.cle && pins.ale))
    else $error("both latch enables high");
  no_fight_a: assert property (!pins.re_n |-> !pins.io_oe)
    else $error("host drives bus during read strobe");
  read_latch_a: assert property (
    !pins.re_n |-> !pins.cle && !pins.ale)
    else $error("latch enable high during read strobe");
  write_drive_a: assert property (!pins.we_n |-> pins.io_oe)
    else $error("write strobe low with bus undriven");
  write_hold_a: assert property ($rose(pins.we_n) |->
    $stable(pins.io_out) && $stable(pins.cle) && $stable(pins.ale))
    else $error("byte or latch changed at write edge");
  we_width_a: assert property (
    $fell(pins.we_n) |=> !pins.we_n[*2])
    else $error("write strobe too short");
  re_width_a: assert property (
    $fell(pins.re_n) |=> !pins.re_n[*2])
    else $error("read strobe too short");
  reset_idle_a: assert property (
    $fell(srst) |-> pins.ce_n && pins.we_n && pins.re_n && !pins.io_oe)
    else $error("pins not idle after reset");
  cover property ($rose(pins.we_n) && pins.cle);
  cover property ($fell(pins.re_n));
  cover property (rsp_valid);
endmodule // nand_host_sva
`default_nettype wire

// *** dv/nand_dev_model.sv ***
// Behavioural NAND device: latches bytes, page buffer, status, busy.
// Assumes the host drives strobes; bus level is resolved here.
`default_nettype none
module nand_dev_model (
  input  wire logic [7:0] host_d,
  input  wire logic       host_oe,
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  output var  logic [7:0] bus,
  output var  logic       ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cmd, q, pg [0:2175];
  int         col, busy_ns;
  bit         drv, stat;
  initial begin
    ready_busy_n = 1'b1;
    busy_ns = 2000;
    drv = 0;
    q = 8'h00;
  end
  // Host wins only when it drives; released bus shows inverted byte
  assign bus = host_oe ? host_d : (drv ? q : ~q);
  always @(posedge we_n) if (!ce_n) begin
    if (cle) begin
      cmd = host_d;
      stat = (host_d == 8'h70);
      if (host_d == 8'h00 || host_d == 8'h80) col = 0;
      if (host_d == 8'hd0) begin
        foreach (pg[i]) pg[i] = 8'hff;
      end
      if (host_d inside {8'h30, 8'h10, 8'hd0, 8'hff, 8'h15,
                         8'h31, 8'h3f, 8'h3a, 8'h11}) begin
        // Busy inside the write-to-busy limit, off the clock edge
        #97 ready_busy_n = 1'b0;
        #(busy_ns) ready_busy_n = 1'b1;
      end
    end else if (!ale) begin
      pg[col] = host_d;
      col = (col + 1) % 2176;
    end
  end
  always @(negedge re_n) if (!ce_n) begin
    drv = 1;
    q = stat ? {1'b0, ready_busy_n, 6'h00} : pg[col];
    if (!stat) col = (col + 1) % 2176;
  end
  always @(posedge re_n) drv = 0;
endmodule // nand_dev_model
`default_nettype wire

// *** dv/test_nand_host_ctrl.sv ***
// Self-checking bench: program, read back, status, timeout, seq error.
// Assumes nand_dev_model as the far side and a 100 MHz ref_clk.
`default_nettype none
module test_nand_host_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, srst = 1, req_valid = 0, rsp_valid, req_ready;
  logic busy_timeout, prog_seq_error, ready_busy_n;
  logic [7:0] rsp_data, io_in;
  nand_host_pkg::req_s  req = '0;
  nand_host_pkg::pins_s pins;
  int miscompares = 0, cmp_count = 0;
  logic [31:0] lfsr = 32'h75b6154d;
  logic [7:0] exp_q [$];
  logic [7:0] cache_cmds [3] = '{8'h31, 8'h3a, 8'h11};
  nand_host_ctrl #(.BUSY_TIMEOUT(2000)) nand_host_ctrl_i (
    .ref_clk(ref_clk), .srst(srst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .busy_timeout(busy_timeout), .prog_seq_error(prog_seq_error),
    .pins(pins), .io_in(io_in), .ready_busy_n(ready_busy_n));
  nand_dev_model nand_dev_model_i (
    .host_d(pins.io_out), .host_oe(pins.io_oe), .ce_n(pins.ce_n),
    .cle(pins.cle), .ale(pins.ale), .we_n(pins.we_n), .re_n(pins.re_n),
    .bus(io_in), .ready_busy_n(ready_busy_n));
  initial forever #5 ref_clk = ~ref_clk;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input nand_host_pkg::phase_e ph,
                      input logic [7:0] d, input bit w);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    req_valid = 1;
    req = '{ph, d, w, 1'b0};
    @(negedge ref_clk);
    req_valid = 0;
    if (w || ph == nand_host_pkg::PH_RDATA) begin
      while (rsp_valid !== 1'b1 && busy_timeout !== 1'b1 && n < 9000) begin
        @(negedge ref_clk);
        n++;
      end
    end
    if (n >= 5000) chk(8'h01, 8'h00);
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(negedge ref_clk);
    srst = 0;
    repeat (2) @(negedge ref_clk);
    send(nand_host_pkg::PH_CMD, 8'h80, 0);
    repeat (2) send(nand_host_pkg::PH_ADDR, 8'h00, 0);
    repeat (6) begin
      lfsr = next_rand(lfsr);
      exp_q.push_back(lfsr[7:0]);
      send(nand_host_pkg::PH_WDATA, lfsr[7:0], 0);
    end
    send(nand_host_pkg::PH_CMD, 8'h10, 1);
    chk({7'h00, rsp_valid}, 8'h01);
    chk(nand_dev_model_i.cmd, 8'h10);
    send(nand_host_pkg::PH_CMD, 8'h70, 0);
    send(nand_host_pkg::PH_RDATA, 8'h00, 0);
    chk(rsp_data, 8'h40);
    send(nand_host_pkg::PH_CMD, 8'h00, 0);
    repeat (2) send(nand_host_pkg::PH_ADDR, 8'h00, 0);
    send(nand_host_pkg::PH_CMD, 8'h30, 1);
    while (exp_q.size() > 0) begin
      send(nand_host_pkg::PH_RDATA, 8'h00, 0);
      chk(rsp_data, exp_q.pop_front());
    end
    foreach (cache_cmds[i]) begin
      send(nand_host_pkg::PH_CMD, cache_cmds[i], 1);
      chk({7'h00, rsp_valid}, 8'h01);
    end
    nand_dev_model_i.busy_ns = 40000;
    send(nand_host_pkg::PH_CMD, 8'hff, 1);
    chk({7'h00, busy_timeout}, 8'h01);
    repeat (4000) @(negedge ref_clk);
    nand_dev_model_i.busy_ns = 2000;
    send(nand_host_pkg::PH_CMD, 8'h15, 1);
    send(nand_host_pkg::PH_CMD, 8'h00, 0);
    repeat (20) @(negedge ref_clk);
    chk({7'h00, prog_seq_error}, 8'h01);
    send(nand_host_pkg::PH_CMD, 8'hff, 1);
    repeat (2) send(nand_host_pkg::PH_CMD, 8'h10, 1);
    chk({7'h00, prog_seq_error}, 8'h00);
    send(nand_host_pkg::PH_CMD, 8'h10, 1);
    chk({7'h00, prog_seq_error}, 8'h01);
    send(nand_host_pkg::PH_CMD, 8'hd0, 1);
    send(nand_host_pkg::PH_CMD, 8'h10, 1);
    chk({7'h00, prog_seq_error}, 8'h00);
    end_of_test();
  end
  initial begin
    #300000;
    miscompares++;
    end_of_test();
  end
endmodule // test_nand_host_ctrl
bind nand_host_ctrl nand_host_sva nand_host_sva_i (
  .ref_clk(ref_clk), .srst(srst), .rsp_valid(rsp_valid), .pins(pins));
`default_nettype wire
